//--- verilog/pps_sequencer.sv
// power sequencer core: key timers, on/off initiation, rail sequencing, fault latches
// assumes all inputs synchronous to clk_i; enable bits and codes come from an I2C register file
`timescale 1ns/10ps

module pps_sequencer import pps_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic power_key_n_i,
    input wire logic hard_reset_n_i,
    input wire logic supply_detect_level_i,
    input wire logic uvlo_release_i,
    input wire logic supply_ovp_i,
    input wire logic main_enable_i,
    input wire logic thermal_shutdown_i,
    input wire logic software_power_off_i,
    input wire logic long_press_off_enable_i,
    input wire logic restart_after_long_press_i,
    input wire logic [1:0] key_on_debounce_select_i,
    input wire logic [1:0] key_off_hold_select_i,
    input wire logic sleep_n_i,
    input wire logic [1:0] sleep_rail_config_i,
    input wire logic [5:0] buck_enable_bits_i,
    input wire logic [1:0] ldo_enable_bits_i,
    input wire logic ldo_enable_write_i,
    input wire logic [5:0] buck_uv_i,
    input wire logic [1:0] ldo_uv_i,
    input wire logic [7:0] rail_ready_i,
    input wire logic fault_clear_i,
    input wire logic [1:0] buck1_vsel_i,
    input wire logic [19:0] dvs_code_i,
    input wire logic [1:0] rtc_vsel_i,
    input wire logic [7:0] ldo_vsel_i,
    output logic [7:0] rail_en_o,
    output logic rtc_ldo_on_o,
    output logic power_good_out_o,
    output logic power_good_oe_o,
    output logic long_press_off_flag_o,
    output logic [5:0] buck_fault_flags_o,
    output logic [1:0] ldo_fault_flags_o,
    output logic ovp_latched_o,
    output logic thermal_latched_o,
    output logic uv_latched_o,
    output logic [1:0] buck1_vsel_o,
    output logic [19:0] dvs_code_o,
    output logic [1:0] rtc_vsel_o,
    output logic [7:0] ldo_vsel_o
);

    if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : g_bad_tick
        $error("TICK_CYCLES must lie in 2..65535");
    end

    // ----------------------------------------------------------------
    // decode functions
    // ----------------------------------------------------------------
    function automatic logic [13:0] key_on_limit(input logic [1:0] sel);
        case (sel)
            2'h0: key_on_limit = DEB_00_TICKS;
            2'h1: key_on_limit = DEB_01_TICKS;
            2'h2: key_on_limit = DEB_10_TICKS;
            default: key_on_limit = DEB_11_TICKS;
        endcase
    endfunction : key_on_limit

    function automatic logic [13:0] key_off_limit(input logic [1:0] sel);
        case (sel)
            2'h0: key_off_limit = LPOFF_00_TICKS;
            2'h1: key_off_limit = LPOFF_01_TICKS;
            2'h2: key_off_limit = LPOFF_10_TICKS;
            default: key_off_limit = LPOFF_11_TICKS;
        endcase
    endfunction : key_off_limit

    function automatic logic [7:0] sleep_mask(input logic [1:0] cfg);
        if (cfg == SLP_ALL_ON) begin
            sleep_mask = 8'hff;
        end else if (cfg == SLP_BUCKS_ONLY) begin
            sleep_mask = 8'h3f;
        end else if (cfg == SLP_BUCK1_ONLY) begin
            sleep_mask = 8'h01;
        end else begin
            sleep_mask = 8'h00;
        end
    endfunction : sleep_mask

    // ----------------------------------------------------------------
    // millisecond timebase
    // ----------------------------------------------------------------
    logic [15:0] pre_cnt;
    logic tick;

    always_ff @(posedge clk_i) begin
        if (rst_i || pre_cnt == 16'(TICK_CYCLES - 1)) begin
            pre_cnt <= 16'h0000;
        end else begin
            pre_cnt <= pre_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        tick <= !rst_i && pre_cnt == 16'(TICK_CYCLES - 1);
    end

    // ----------------------------------------------------------------
    // edge detectors
    // ----------------------------------------------------------------
    logic hrst_q, det_q, uvlo_q, men_q;
    logic reset_fall, det_rise, uvlo_rise, men_toggle;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hrst_q <= 1'b1;
            det_q <= 1'b0;
            uvlo_q <= 1'b0;
            men_q <= main_enable_i;
        end else begin
            hrst_q <= hard_reset_n_i;
            det_q <= supply_detect_level_i;
            uvlo_q <= uvlo_release_i;
            men_q <= main_enable_i;
        end
    end

    assign reset_fall = hrst_q && !hard_reset_n_i;
    assign det_rise = !det_q && supply_detect_level_i;
    assign uvlo_rise = !uvlo_q && uvlo_release_i;
    assign men_toggle = men_q != main_enable_i;

    // ----------------------------------------------------------------
    // key hold timer
    // ----------------------------------------------------------------
    pps_state_t st;
    logic [13:0] key_cnt;
    logic key_armed;
    logic key_on_hit, key_off_hit, key_fire;
    logic is_active, is_idle;

    assign is_active = st == ST_UP || st == ST_WAIT_PG || st == ST_ON;
    assign is_idle = st == ST_OFF || st == ST_RESTART;
    // strictly longer than the selected time
    assign key_on_hit = key_armed && !power_key_n_i &&
                        key_cnt > key_on_limit(key_on_debounce_select_i);
    assign key_off_hit = key_armed && !power_key_n_i && long_press_off_enable_i && is_active &&
                         key_cnt > key_off_limit(key_off_hold_select_i);
    assign key_fire = (key_on_hit && is_idle) || key_off_hit;

    // one action per press: a held key cannot turn the device back on after a long-press off
    always_ff @(posedge clk_i) begin
        if (rst_i || power_key_n_i) begin
            key_cnt <= 14'h0000;
            key_armed <= !rst_i;
        end else if (key_fire) begin
            key_cnt <= 14'h0000;
            key_armed <= 1'b0;
        end else if (tick && key_cnt != 14'h3fff) begin
            key_cnt <= key_cnt + 14'h0001;
        end
    end

    // ----------------------------------------------------------------
    // buck under-voltage filters
    // ----------------------------------------------------------------
    logic [5:0] uv_hit;
    logic uv_trip;

    for (genvar b = 0; b < NUM_BUCK; b++) begin : g_uv
        logic [7:0] uv_cnt;
        always_ff @(posedge clk_i) begin
            if (rst_i || !buck_uv_i[b] || !rail_en_o[b]) begin
                uv_cnt <= 8'h00;
            end else if (tick && uv_cnt != 8'hff) begin
                uv_cnt <= uv_cnt + 8'h01;
            end
        end
        assign uv_hit[b] = buck_uv_i[b] && uv_cnt > UV_LIMIT_TICKS;
    end

    assign uv_trip = |uv_hit;

    // ----------------------------------------------------------------
    // initiation conditions
    // ----------------------------------------------------------------
    logic ovp_latched, pg;
    logic [13:0] tcnt;
    logic init_on, init_off, soft_ok, go_down;
    pps_cause_t cause, next_cause;

    assign soft_ok = software_power_off_i && st == ST_ON && pg && !supply_detect_level_i;
    assign init_on = is_idle && !ovp_latched && hard_reset_n_i &&
                     (key_on_hit || det_rise || uvlo_rise ||
                      (st == ST_RESTART && tick && tcnt == RESTART_TICKS));
    assign init_off = reset_fall || key_off_hit;

    always_comb begin
        next_cause = CAUSE_NONE;
        if (reset_fall) begin
            next_cause = CAUSE_RESET;
        end else if (is_active && supply_ovp_i) begin
            next_cause = CAUSE_OVP;
        end else if (is_active && thermal_shutdown_i) begin
            next_cause = CAUSE_TSD;
        end else if (is_active && uv_trip) begin
            next_cause = CAUSE_UV;
        end else if (key_off_hit) begin
            next_cause = CAUSE_LPOFF;
        end else if (soft_ok) begin
            next_cause = CAUSE_SOFT;
        end
    end

    assign go_down = next_cause != CAUSE_NONE;

    // ----------------------------------------------------------------
    // sequencing state machine
    // ----------------------------------------------------------------
    logic [2:0] idx;
    logic [7:0] seq_mask, rail_req;
    logic restart_pending;

    assign rail_req = {ldo_enable_bits_i, buck_enable_bits_i};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= ST_OFF;
            idx <= 3'h0;
            tcnt <= 14'h0000;
            seq_mask <= 8'h00;
            cause <= CAUSE_NONE;
        end else if (go_down) begin
            st <= ST_DOWN;
            idx <= LAST_RAIL;
            tcnt <= 14'h0000;
            cause <= next_cause;
        end else begin
            case (st)
                ST_OFF, ST_RESTART: begin
                    if (init_on) begin
                        st <= ST_UP;
                        idx <= 3'h0;
                        tcnt <= 14'h0000;
                        cause <= CAUSE_NONE;
                    end else if (st == ST_RESTART && tick) begin
                        tcnt <= tcnt + 14'h0001;
                    end
                end
                ST_UP: begin
                    // a rail whose enable bit is clear is skipped, not waited for
                    seq_mask[idx] <= 1'b1;
                    if (!rail_req[idx] || (seq_mask[idx] && rail_ready_i[idx])) begin
                        if (idx == LAST_RAIL) begin
                            st <= ST_WAIT_PG;
                            tcnt <= 14'h0000;
                        end else begin
                            idx <= idx + 3'h1;
                        end
                    end
                end
                ST_WAIT_PG: begin
                    if (tick) begin
                        tcnt <= tcnt + 14'h0001;
                        if (tcnt == PG_DELAY_TICKS - 14'h0001) begin
                            st <= ST_ON;
                        end
                    end
                end
                ST_ON: begin
                    st <= ST_ON;
                end
                ST_DOWN: begin
                    // one rail per tick, highest first; power-good already low
                    if (tick) begin
                        seq_mask[idx] <= 1'b0;
                        idx <= idx - 3'h1;
                        if (idx == 3'h0) begin
                            st <= restart_pending ? ST_RESTART : ST_OFF;
                            tcnt <= 14'h0000;
                        end
                    end
                end
                default: begin
                    st <= ST_OFF;
                end
            endcase
        end
    end

    assign restart_pending = cause == CAUSE_RESET ||
                             (cause == CAUSE_LPOFF && long_press_off_enable_i && restart_after_long_press_i);

    // ----------------------------------------------------------------
    // power-good, open drain
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || go_down) begin
            pg <= 1'b0;
        end else if (st == ST_WAIT_PG && tick && tcnt == PG_DELAY_TICKS - 14'h0001) begin
            pg <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        power_good_out_o <= 1'b0;
        power_good_oe_o <= rst_i || !pg;
    end

    // ----------------------------------------------------------------
    // fault latches and records
    // ----------------------------------------------------------------
    logic [1:0] ldo_uv_off;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovp_latched <= 1'b0;
        end else if (supply_ovp_i) begin
            ovp_latched <= 1'b1;
        end else if (men_toggle) begin
            ovp_latched <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thermal_latched_o <= 1'b0;
            uv_latched_o <= 1'b0;
        end else begin
            // a fresh fault beats an initiation in the same cycle
            thermal_latched_o <= (thermal_latched_o && !(init_on || init_off)) ||
                                 (is_active && thermal_shutdown_i);
            uv_latched_o <= (uv_latched_o && !(init_on || init_off)) || (is_active && uv_trip);
        end
    end

    // set wins over every clear so a fresh fault is never dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ldo_uv_off <= 2'h0;
        end else begin
            ldo_uv_off <= (init_on || init_off || ldo_enable_write_i) ? 2'h0 : ldo_uv_off;
            for (int j = 0; j < NUM_LDO; j++) begin
                if (ldo_uv_i[j] && rail_en_o[NUM_BUCK + j]) begin
                    ldo_uv_off[j] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buck_fault_flags_o <= 6'h00;
            ldo_fault_flags_o <= 2'h0;
        end else begin
            buck_fault_flags_o <= (fault_clear_i ? 6'h00 : buck_fault_flags_o) | uv_hit;
            ldo_fault_flags_o <= (fault_clear_i ? 2'h0 : ldo_fault_flags_o) |
                                 (ldo_uv_i & rail_en_o[7:6]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || init_on) begin
            long_press_off_flag_o <= 1'b0;
        end else if (key_off_hit) begin
            long_press_off_flag_o <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // rail enables and voltage codes
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rail_en_o <= 8'h00;
            rtc_ldo_on_o <= 1'b0;
        end else begin
            rail_en_o <= seq_mask & rail_req & ~{ldo_uv_off, 6'h00} &
                         ((st == ST_ON && !sleep_n_i) ? sleep_mask(sleep_rail_config_i) : 8'hff);
            rtc_ldo_on_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        ovp_latched_o <= ovp_latched;
        buck1_vsel_o <= buck1_vsel_i;
        rtc_vsel_o <= rtc_vsel_i;
        dvs_code_o <= dvs_code_i;
        ldo_vsel_o <= ldo_vsel_i;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_up_done;
        st == ST_UP ##1 st == ST_WAIT_PG;
    endsequence

    chk_pg_after_up: assert property (@(posedge clk_i) disable iff (rst_i)
        s_up_done |-> !pg && power_good_oe_o)
        else $error("power-good high before the delay ran");
    chk_pg_from_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(pg) |-> $past(st) == ST_WAIT_PG && $past(tcnt) == PG_DELAY_TICKS - 14'h0001 && $past(tick))
        else $error("power-good rose without the 8 ms delay");
    chk_reset_down: assert property (@(posedge clk_i) disable iff (rst_i)
        reset_fall |=> st == ST_DOWN && cause == CAUSE_RESET)
        else $error("hard reset did not start power-off");
    chk_pg_first: assert property (@(posedge clk_i) disable iff (rst_i)
        st == ST_DOWN |-> !pg)
        else $error("rail disabled while power-good high");
    chk_soft_guard: assert property (@(posedge clk_i) disable iff (rst_i)
        (st == ST_DOWN && $changed(st) && cause == CAUSE_SOFT) |-> $past(pg) && !$past(supply_detect_level_i))
        else $error("software off taken outside its window");
    chk_lp_enable: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(long_press_off_flag_o) |-> $past(long_press_off_enable_i) && $past(key_cnt) > LPOFF_00_TICKS)
        else $error("long-press off without enable or hold time");
    chk_uv_short: assert property (@(posedge clk_i) disable iff (rst_i)
        (buck_uv_i == 6'h00) |=> !uv_latched_o || $past(uv_latched_o))
        else $error("buck under-voltage shutdown without a long fault");
    chk_ldo_uv_off: assert property (@(posedge clk_i) disable iff (rst_i)
        ldo_uv_off[0] |=> !rail_en_o[6])
        else $error("LDO2 left on after its under-voltage");
    chk_restart_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        ($past(st) == ST_RESTART && st == ST_UP && !$past(key_on_hit) && !$past(det_rise) && !$past(uvlo_rise))
        |-> $past(tcnt) == RESTART_TICKS)
        else $error("restart did not wait one second");
    chk_ovp_block: assert property (@(posedge clk_i) disable iff (rst_i)
        (ovp_latched && is_idle) |=> st != ST_UP)
        else $error("power-on while over-voltage latched");

endmodule : pps_sequencer

//--- verilog/pps_pkg.sv
// constants, state codes and timing for the power sequencer
// assumes a 20 MHz clock and a slow millisecond timebase built in the sequencer

package pps_pkg;

    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_TIME_NS = 1000000;
    localparam int TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;

    // all hold times counted in 1 ms ticks
    localparam int TICK_MS = 1;
    localparam logic [13:0] DEB_00_TICKS = 14'(128 / TICK_MS);
    localparam logic [13:0] DEB_01_TICKS = 14'(500 / TICK_MS);
    localparam logic [13:0] DEB_10_TICKS = 14'(1000 / TICK_MS);
    localparam logic [13:0] DEB_11_TICKS = 14'(1500 / TICK_MS);
    localparam logic [13:0] LPOFF_00_TICKS = 14'(6000 / TICK_MS);
    localparam logic [13:0] LPOFF_01_TICKS = 14'(7000 / TICK_MS);
    localparam logic [13:0] LPOFF_10_TICKS = 14'(8000 / TICK_MS);
    localparam logic [13:0] LPOFF_11_TICKS = 14'(10000 / TICK_MS);
    localparam logic [13:0] RESTART_TICKS = 14'(1000 / TICK_MS);
    localparam logic [13:0] PG_DELAY_TICKS = 14'(8 / TICK_MS);
    localparam logic [7:0] UV_LIMIT_TICKS = 8'(128 / TICK_MS);

    localparam int NUM_BUCK = 6;
    localparam int NUM_LDO = 2;
    localparam int NUM_RAIL = NUM_BUCK + NUM_LDO;
    localparam logic [2:0] LAST_RAIL = 3'h7;

    localparam logic [1:0] SLP_ALL_ON = 2'h0;
    localparam logic [1:0] SLP_BUCKS_ONLY = 2'h1;
    localparam logic [1:0] SLP_BUCK1_ONLY = 2'h2;

    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_UP = 6'h02,
        ST_WAIT_PG = 6'h04,
        ST_ON = 6'h08,
        ST_DOWN = 6'h10,
        ST_RESTART = 6'h20
    } pps_state_t;

    typedef enum logic [2:0] {
        CAUSE_NONE = 3'h0,
        CAUSE_RESET = 3'h1,
        CAUSE_OVP = 3'h2,
        CAUSE_TSD = 3'h3,
        CAUSE_UV = 3'h4,
        CAUSE_LPOFF = 3'h5,
        CAUSE_SOFT = 3'h6
    } pps_cause_t;

endpackage : pps_pkg

//--- bench/pps_rail_model.sv
// rail ready model standing in for the converters behind the sequencer
// assumes rail enables come from the sequencer on the same clock
`timescale 1ns/10ps

module pps_rail_model (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic [7:0] rail_en_i,
    output logic [7:0] rail_ready_o
);
    // ------------------------------
    // soft-start delay
    // ------------------------------
    logic [7:0] d1, d2, d3;
    always_ff @(posedge clk_i) begin
        d1 <= rail_en_i;
        d2 <= d1 & rail_en_i;
        d3 <= d2 & rail_en_i;
    end
    // a dropped enable clears ready at once, so a stale ready never leaks into the next power-up
    assign rail_ready_o = rail_en_i & (slow_i ? d3 : d1);
endmodule : pps_rail_model

//--- bench/pmic_power_sequencer_tb.sv
// self-checking bench for the power sequencer, rails answered by the ready model
// assumes the tick is shortened to 4 clocks; times below are counted in clocks, with tick times written as multiples of TK
`timescale 1ns/10ps

module pmic_power_sequencer_tb import pps_pkg::*;;
    localparam int TK = 4;
    logic clk_i, rst_i, power_key_n_i, hard_reset_n_i, supply_detect_level_i, uvlo_release_i, supply_ovp_i;
    logic main_enable_i, thermal_shutdown_i, software_power_off_i, long_press_off_enable_i, sleep_n_i;
    logic restart_after_long_press_i, ldo_enable_write_i, fault_clear_i, slow;
    logic [1:0] key_on_debounce_select_i, key_off_hold_select_i, sleep_rail_config_i, ldo_enable_bits_i, ldo_uv_i;
    logic [1:0] buck1_vsel_i, rtc_vsel_i, ldo_fault_flags_o, buck1_vsel_o, rtc_vsel_o;
    logic [5:0] buck_enable_bits_i, buck_uv_i, buck_fault_flags_o;
    logic [7:0] rail_ready_i, ldo_vsel_i, rail_en_o, ldo_vsel_o, prev, newb;
    logic [19:0] dvs_code_i, dvs_code_o;
    logic rtc_ldo_on_o, power_good_out_o, power_good_oe_o, long_press_off_flag_o;
    logic ovp_latched_o, thermal_latched_o, uv_latched_o;
    int n_errors = 0;
    int checks_done = 0;
    int n;
    int lo;

    pps_sequencer #(.TICK_CYCLES(TK)) dut_u (.*);
    pps_rail_model model_u (.clk_i(clk_i), .slow_i(slow), .rail_en_i(rail_en_o), .rail_ready_o(rail_ready_i));

    // ------------------------------
    // helpers
    // ------------------------------
    function automatic int deb_ticks(input logic [1:0] s);
        return (s == 2'h0) ? 128 : (s == 2'h1) ? 500 : (s == 2'h2) ? 1000 : 1500;
    endfunction : deb_ticks
    function automatic logic [7:0] sleep_exp(input logic [1:0] c);
        return (c == 2'h0) ? 8'hff : (c == 2'h1) ? 8'h3f : (c == 2'h2) ? 8'h01 : 8'h00;
    endfunction : sleep_exp
    task automatic step(input int c);
        repeat (c) @(posedge clk_i);
        #5;
    endtask : step
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t got %0h expected %0h", $time, g, e);
        end
    endtask : chk
    // bounded wait on the open-drain enable; n keeps the cycles taken
    task automatic wait_oe(input logic v, input int lim);
        n = 0;
        while (power_good_oe_o !== v && n < lim) begin
            step(1);
            n++;
        end
        chk(n < lim, 1);
    endtask : wait_oe
    task automatic pulse_soft();
        software_power_off_i = 1;
        step(1);
        software_power_off_i = 0;
    endtask : pulse_soft
    task automatic off_check();
        step(12 * TK);
        chk(power_good_oe_o, 1);
        chk(rail_en_o, 0);
    endtask : off_check
    task automatic report_and_stop();
        if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    initial begin
        clk_i = 0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        #(90000 * 50);
        n_errors++;
        report_and_stop();
    end

    // rails only fall with power good withdrawn, and rise in order
    always @(posedge clk_i) begin
        newb = rail_en_o & ~prev;
        // sleep and LDO under-voltage may drop rails with power good still released
        if (!rst_i && sleep_n_i && power_good_oe_o === 1'b0 && (prev[5:0] & ~rail_en_o[5:0]) != 6'h0) chk(0, 1);
        if (!rst_i && newb != 8'h0 &&
            ((newb - 8'h1) & ~newb & {ldo_enable_bits_i, buck_enable_bits_i} & ~rail_en_o) != 8'h0) chk(0, 1);
        prev = rail_en_o;
    end

    // ------------------------------
    // scenarios
    // ------------------------------
    initial begin
        void'($urandom(32'h99f9));
        {power_key_n_i, hard_reset_n_i, sleep_n_i, main_enable_i, rst_i} = 5'h1f;
        {supply_detect_level_i, uvlo_release_i, supply_ovp_i, thermal_shutdown_i, software_power_off_i} = 5'h0;
        {long_press_off_enable_i, restart_after_long_press_i, ldo_enable_write_i, fault_clear_i, slow} = 5'h0;
        {key_on_debounce_select_i, key_off_hold_select_i, sleep_rail_config_i, ldo_uv_i} = 8'h0;
        {buck_uv_i, prev, ldo_enable_bits_i, buck_enable_bits_i} = {6'h0, 8'h0, 8'hff};
        {buck1_vsel_i, rtc_vsel_i, ldo_vsel_i, dvs_code_i} = 32'($urandom);
        step(4);
        rst_i = 0;
        step(1);
        chk(rail_en_o, 0);
        chk(power_good_oe_o, 1);
        chk(rtc_ldo_on_o, 1);
        chk(power_good_out_o, 0);
        chk({buck1_vsel_o, rtc_vsel_o, ldo_vsel_o, dvs_code_o}, {buck1_vsel_i, rtc_vsel_i, ldo_vsel_i, dvs_code_i});
        for (int s = 0; s < 4; s++) begin
            key_on_debounce_select_i = 2'(s);
            buck_enable_bits_i = 6'($urandom) | 6'h01;
            slow = s[0];
            power_key_n_i = 0;
            n = 0;
            while (rail_en_o === 8'h0 && n < 7000) begin
                step(1);
                n++;
            end
            lo = deb_ticks(key_on_debounce_select_i) * TK;
            chk(n > lo && n <= lo + 3 * TK, 1);
            power_key_n_i = 1;
            while (rail_ready_i[7] !== 1'b1 && n < 8000) begin
                step(1);
                n++;
            end
            wait_oe(0, 200);
            chk(n >= 7 * TK && n <= 9 * TK, 1);
            chk(rail_en_o, {ldo_enable_bits_i, buck_enable_bits_i});
            supply_detect_level_i = 1;
            pulse_soft();
            step(4 * TK);
            chk(power_good_oe_o, 0);
            supply_detect_level_i = 0;
            pulse_soft();
            off_check();
        end
        uvlo_release_i = 1;
        wait_oe(0, 400);
        uvlo_release_i = 0;
        hard_reset_n_i = 0;
        step(2);
        hard_reset_n_i = 1;
        off_check();
        wait_oe(0, 1100 * TK);
        chk(n > 980 * TK, 1);
        ldo_uv_i = 2'h1;
        step(1);
        ldo_uv_i = 2'h0;
        step(1);
        chk(ldo_fault_flags_o, 2'h1);
        chk(rail_en_o[6], 0);
        ldo_enable_write_i = 1;
        step(1);
        ldo_enable_write_i = 0;
        fault_clear_i = 1;
        step(1);
        fault_clear_i = 0;
        step(2);
        chk(ldo_fault_flags_o, 0);
        chk(rail_en_o[6], 1);
        thermal_shutdown_i = 1;
        step(1);
        thermal_shutdown_i = 0;
        off_check();
        chk(thermal_latched_o, 1);
        supply_detect_level_i = 1;
        wait_oe(0, 400);
        chk(thermal_latched_o, 0);
        supply_detect_level_i = 0;
        sleep_n_i = 0;
        for (int c = 0; c < 4; c++) begin
            sleep_rail_config_i = 2'(c);
            step(2);
            chk(rail_en_o, {ldo_enable_bits_i, buck_enable_bits_i} & sleep_exp(2'(c)));
            chk(power_good_oe_o, 0);
        end
        sleep_n_i = 1;
        step(2);
        chk(rail_en_o, {ldo_enable_bits_i, buck_enable_bits_i});
        buck_uv_i = 6'h01;
        step(100 * TK);
        buck_uv_i = 6'h00;
        step(1);
        chk({power_good_oe_o, uv_latched_o, buck_fault_flags_o}, 0);
        buck_uv_i = 6'h01;
        step(135 * TK);
        chk({power_good_oe_o, uv_latched_o, buck_fault_flags_o}, 8'hc1);
        buck_uv_i = 6'h00;
        off_check();
        supply_detect_level_i = 1;
        wait_oe(0, 400);
        chk(uv_latched_o, 0);
        supply_detect_level_i = 0;
        {long_press_off_enable_i, restart_after_long_press_i} = 2'h3;
        power_key_n_i = 0;
        wait_oe(1, 6100 * TK);
        chk(n > 6000 * TK && long_press_off_flag_o, 1);
        power_key_n_i = 1;
        wait_oe(0, 1100 * TK);
        chk(long_press_off_flag_o, 0);
        key_on_debounce_select_i = 2'h0;
        supply_ovp_i = 1;
        step(1);
        supply_ovp_i = 0;
        off_check();
        chk(ovp_latched_o, 1);
        power_key_n_i = 0;
        step(200 * TK);
        power_key_n_i = 1;
        chk(rail_en_o, 0);
        main_enable_i = 0;
        step(2);
        chk(ovp_latched_o, 0);
        report_and_stop();
    end
endmodule : pmic_power_sequencer_tb
